// ==== rao_fifo.sv ====
// Small synchronous FIFO with registered full and empty flags
`timescale 1ns/10ps
`default_nettype none
module rao_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic   clock,  // Core clock
	input  wire logic   resetn, // Synchronous reset, active low
	rao_stream_if.snk   wr,     // Filling side
	rao_stream_if.src   rd      // Draining side
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic             room;
	logic             empty;
	wire              push = wr.valid & room;
	wire              pop  = ~empty & rd.ready;
	wire [CW-1:0]     next_count = count + CW'(push) - CW'(pop);

	// Ready comes straight from a flop, with no gate after it
	assign wr.ready = room;
	assign rd.valid = ~empty;
	assign rd.data  = mem[rd_ptr];

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= wr.data;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
			room   <= 1'b1;
			empty  <= 1'b1;
		end else begin
			wr_ptr <= push ? ((wr_ptr == PTR_LAST) ? '0 : wr_ptr + PW'(1))
				: wr_ptr;
			rd_ptr <= pop ? ((rd_ptr == PTR_LAST) ? '0 : rd_ptr + PW'(1))
				: rd_ptr;
			count  <= next_count;
			room   <= next_count != FULL_CNT;
			empty  <= next_count == '0;
		end
	end
endmodule : rao_fifo
`default_nettype wire

// ==== rao_host_model.sv ====
// Host model that frames the serial link and reads words MSB first
`timescale 1ns/10ps
`default_nettype none
module rao_host_model (
	output logic      serial_shift_clock, // Host-made shift clock
	output logic      chip_select,        // Frame, active high
	output logic      serial_data_in,     // Level seen on the data line
	input  wire logic serial_data_out,    // Device drive value
	input  wire logic serial_data_oe      // Device drives the line
);
	logic last = 1'b0;
	// A released line shows the inverse so a stale value never passes
	assign serial_data_in = serial_data_oe ? serial_data_out : ~last;
	always @* if (serial_data_oe) last = serial_data_out;
	initial begin
		serial_shift_clock = 1'b0;
		chip_select = 1'b0;
	end
	// frame opened by raising select, then settle time
	task open_frame;
		chip_select = 1'b1;
		#60;
	endtask : open_frame
	// host clocks each bit; clock stands still outside frames
	task shift_word(output logic [15:0] w, output logic oe_ok);
		w = 16'h0000;
		oe_ok = 1'b1;
		repeat (16) begin
			#15 serial_shift_clock = 1'b1;
			#15 serial_shift_clock = 1'b0;
			w = {w[14:0], serial_data_in};
			oe_ok = oe_ok & serial_data_oe;
		end
	endtask : shift_word
	// select low long enough for the next word to load
	task close_frame;
		#15 chip_select = 1'b0;
		#90;
	endtask : close_frame
	task read_frame(output logic [15:0] w, output logic oe_ok);
		open_frame;
		shift_word(w, oe_ok);
		close_frame;
	endtask : read_frame
endmodule : rao_host_model
`default_nettype wire

// ==== rao_pkg.sv ====
// Constants and helpers of the rotary angle output logic
//
// Summary of operation
// - Quantize each measured angle to an unsigned 8-bit code, 256 positions.
// - PWM high time grows by 0.5 us per code step.
// - Field-low flag is high while field is weak, low otherwise.
// - Chip select is active high; serial link acts only while it is high.
// - Keep the last measured angle in a storage register during polling.
// - Pull wake output low when polling sees the angle change.
// - Count full revolutions in a turn counter readable by the host.
// - Any position may be set as zero; codes are relative to it.
`default_nettype none
package rao_pkg;
	localparam int         RAW_W          = 12;
	localparam int         ANGLE_W        = 8;
	localparam int         TURN_W         = 8;
	localparam int         WORD_W         = 16;
	localparam int         FIFO_DEPTH     = 4;
	localparam int         QUANT_LSB      = RAW_W - ANGLE_W;
	localparam int         WORD_ANGLE_LSB = 0;
	localparam int         WORD_TURN_LSB  = 8;
	localparam int         QUAD_LSB       = 6;
	localparam logic [7:0] ANGLE_RST      = 8'h00;
	localparam logic [7:0] TURN_RST       = 8'h00;
	localparam logic [15:0] WORD_RST      = 16'h0000;
	localparam int         CLK_PERIOD_NS  = 10;
	localparam int         PWM_STEP_NS    = 500;
	localparam int         PWM_STEP_CYC   =
		(PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] PWM_STEP_LAST  = 6'(PWM_STEP_CYC - 1);
	localparam int         PWM_SLOTS      = 258;
	localparam logic [8:0] PWM_SLOT_LAST  = 9'(PWM_SLOTS - 1);
	localparam int         FRAME_BITS     = 16;
	localparam logic [4:0] FRAME_END      = 5'(FRAME_BITS);

	// Forward wrap: top quadrant to bottom quadrant
	function automatic logic rao_wrap_up(
		input logic [7:0] prev,
		input logic [7:0] next_v
	);
		return (prev[7:QUAD_LSB] == 2'h3) && (next_v[7:QUAD_LSB] == 2'h0);
	endfunction : rao_wrap_up

	function automatic logic rao_wrap_dn(
		input logic [7:0] prev,
		input logic [7:0] next_v
	);
		return rao_wrap_up(next_v, prev);
	endfunction : rao_wrap_dn
endpackage : rao_pkg
`default_nettype wire

// ==== rao_stream_if.sv ====
// Valid/ready stream carrier between the block's own modules
`timescale 1ns/10ps
`default_nettype none
interface rao_stream_if #(
	parameter int WIDTH = 16
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : rao_stream_if
`default_nettype wire

// ==== rao_top.sv ====
// Angle coding, turn counting, wake, PWM and serial readout
`timescale 1ns/10ps
`default_nettype none
module rao_top (
	input  wire logic        clock,              // Core clock, 100 MHz
	input  wire logic        resetn,             // Sync reset, active low
	input  wire logic [11:0] raw_angle,          // Front-end angle sample
	input  wire logic        angle_valid,        // Sample offered
	output logic             angle_ready,        // Sample can be taken
	input  wire logic        field_weak,         // Async field-weak level
	input  wire logic        zero_set,           // Pulse: current = zero
	input  wire logic        polling_mode,       // Pulsed-supply polling
	input  wire logic        serial_shift_clock, // Host shift clock
	input  wire logic        chip_select,        // Frame, active high
	input  wire logic        serial_data_in,     // Data line level
	output logic             serial_data_out,    // Data line drive value
	output logic             serial_data_oe,     // Data line enable
	output logic             pwm_out,            // Angle as pulse width
	output logic             field_low_flag,     // High when field weak
	output logic             wake_out,           // Wake drive value
	output logic             wake_oe             // Wake pulled low
);
	// ==============================================================
	// Sample path
	// ==============================================================
	rao_stream_if #(.WIDTH(rao_pkg::WORD_W)) push_if ();
	rao_stream_if #(.WIDTH(rao_pkg::WORD_W)) pop_if ();

	logic [7:0]  zero_pos;
	logic [7:0]  angle_code;
	logic [7:0]  turns;
	logic [7:0]  stored_angle;
	logic [15:0] shadow;

	wire         take = angle_valid & push_if.ready;
	// Quantize: keep the top bits of the front-end sample
	wire [7:0]   quant = raw_angle[rao_pkg::QUANT_LSB +: rao_pkg::ANGLE_W];
	wire [7:0]   next_code = quant - zero_pos;
	wire         wrap_up = rao_pkg::rao_wrap_up(angle_code, next_code);
	wire         wrap_dn = rao_pkg::rao_wrap_dn(angle_code, next_code);
	wire [7:0]   next_turns = wrap_up ? turns + 8'h01
		: (wrap_dn ? turns - 8'h01 : turns);

	assign push_if.valid = angle_valid;
	assign push_if.data  = {next_turns, next_code};
	assign angle_ready   = push_if.ready;

	// Readout words queue while a frame holds the shadow word frozen
	rao_fifo #(
		.WIDTH (rao_pkg::WORD_W),
		.DEPTH (rao_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock  (clock),
		.resetn (resetn),
		.wr     (push_if.snk),
		.rd     (pop_if.src)
	);

	always_ff @(posedge clock) begin
		if (!resetn) begin
			zero_pos <= rao_pkg::ANGLE_RST;
		end else if (zero_set) begin
			zero_pos <= quant;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			angle_code   <= rao_pkg::ANGLE_RST;
			stored_angle <= rao_pkg::ANGLE_RST;
		end else if (take) begin
			angle_code   <= next_code;
			stored_angle <= next_code;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			turns <= rao_pkg::TURN_RST;
		end else if (take) begin
			turns <= next_turns;
		end
	end

	// ==============================================================
	// Chip select seen from the core clock
	// ==============================================================
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	wire  readout_done = cs_prev & ~cs_sync;
	wire  pop = pop_if.valid & pop_if.ready;

	// Shadow only moves between frames, so the link reads a still word
	assign pop_if.ready = ~cs_sync;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			cs_meta <= 1'b0;
			cs_sync <= 1'b0;
			cs_prev <= 1'b0;
		end else begin
			cs_meta <= chip_select;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			shadow <= rao_pkg::WORD_RST;
		end else if (pop) begin
			shadow <= pop_if.data;
		end
	end

	// ==============================================================
	// Wake output
	// ==============================================================
	// motion in polling
	wire motion = take & polling_mode & (next_code != stored_angle);
	// release after readout; a new motion outranks the clear
	wire next_wake = motion | (wake_oe & ~readout_done);

	always_ff @(posedge clock) begin
		if (!resetn) begin
			wake_oe  <= 1'b0;
			wake_out <= 1'b0;
		end else begin
			wake_oe  <= next_wake;
			wake_out <= 1'b0;
		end
	end

	// ==============================================================
	// Field-low flag
	// ==============================================================
	logic fw_meta;
	logic fw_sync;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			fw_meta        <= 1'b0;
			fw_sync        <= 1'b0;
			field_low_flag <= 1'b0;
		end else begin
			fw_meta        <= field_weak;
			fw_sync        <= fw_meta;
			field_low_flag <= fw_sync;
		end
	end

	// ==============================================================
	// Pulse-width output
	// ==============================================================
	logic [5:0] step_cnt;
	logic [8:0] slot_cnt;
	logic [7:0] pwm_code;

	wire step_end = step_cnt == rao_pkg::PWM_STEP_LAST;
	wire period_end = step_end & (slot_cnt == rao_pkg::PWM_SLOT_LAST);
	wire [8:0] next_slot = period_end ? 9'h000
		: (step_end ? slot_cnt + 9'h001 : slot_cnt);
	// high for code plus one steps
	wire pwm_level = slot_cnt <= {1'b0, pwm_code};

	// The code is latched per period so a moving shaft cannot cut a pulse
	always_ff @(posedge clock) begin
		if (!resetn) begin
			step_cnt <= 6'h00;
			slot_cnt <= 9'h000;
			pwm_code <= rao_pkg::ANGLE_RST;
			pwm_out  <= 1'b0;
		end else begin
			step_cnt <= step_end ? 6'h00 : step_cnt + 6'h01;
			slot_cnt <= next_slot;
			pwm_code <= period_end ? angle_code : pwm_code;
			pwm_out  <= pwm_level;
		end
	end

	// ==============================================================
	// Serial link, on the host's shift clock
	// ==============================================================
	logic [4:0]  bit_cnt;
	logic [15:0] shreg;

	wire first_bit = bit_cnt == 5'h00;
	wire in_frame  = bit_cnt != rao_pkg::FRAME_END;
	wire [15:0] next_shreg = first_bit ? {shadow[14:0], 1'b0}
		: {shreg[14:0], 1'b0};
	wire next_sd = first_bit ? shadow[15] : (in_frame & shreg[15]);
	wire [4:0] next_bit_cnt = in_frame ? bit_cnt + 5'h01 : bit_cnt;

	always_ff @(posedge serial_shift_clock or negedge chip_select) begin
		if (!chip_select) begin
			bit_cnt         <= 5'h00;
			shreg           <= rao_pkg::WORD_RST;
			serial_data_out <= 1'b0;
			serial_data_oe  <= 1'b0;
		end else begin
			bit_cnt         <= next_bit_cnt;
			shreg           <= next_shreg;
			serial_data_out <= next_sd;
			serial_data_oe  <= 1'b1;
		end
	end

	// ==============================================================
	// Checks
	// ==============================================================
	logic [13:0] hi_cnt;
	wire  [13:0] pwm_expect =
		14'((32'(pwm_code) + 1) * rao_pkg::PWM_STEP_CYC);

	always_ff @(posedge clock) begin
		if (!resetn) begin
			hi_cnt <= 14'h0000;
		end else begin
			hi_cnt <= pwm_out ? hi_cnt + 14'h0001 : 14'h0000;
		end
	end

	property p_quant;
		@(posedge clock) disable iff (!resetn)
		take && !zero_set |=> angle_code ==
			8'($past(raw_angle[11:4]) - $past(zero_pos));
	endproperty
	a_quant: assert property (p_quant)
		else $error("angle code not quantized sample");

	property p_pwm_width;
		@(posedge clock) disable iff (!resetn)
		$fell(pwm_out) |-> hi_cnt == pwm_expect;
	endproperty
	a_pwm_width: assert property (p_pwm_width)
		else $error("pwm high width wrong");

	property p_field;
		@(posedge clock) disable iff (!resetn)
		(field_weak[*4] |-> field_low_flag) and
		(!field_weak[*4] |-> !field_low_flag);
	endproperty
	a_field: assert property (p_field)
		else $error("field low flag wrong");

	property p_link_quiet;
		@(posedge clock) disable iff (!resetn)
		!cs_sync |-> !serial_data_oe;
	endproperty
	a_link_quiet: assert property (p_link_quiet)
		else $error("data line driven outside frame");

	property p_store;
		@(posedge clock) disable iff (!resetn)
		take |=> stored_angle == $past(next_code);
	endproperty
	a_store: assert property (p_store)
		else $error("stored angle not updated");

	property p_wake_set;
		@(posedge clock) disable iff (!resetn)
		take && polling_mode && (next_code != stored_angle)
			|=> wake_oe && !wake_out;
	endproperty
	a_wake_set: assert property (p_wake_set)
		else $error("wake not asserted on motion");

	property p_turn_up;
		@(posedge clock) disable iff (!resetn)
		take && angle_code[7:6] == 2'h3 && next_code[7:6] == 2'h0
			|=> turns == 8'($past(turns) + 8'h01);
	endproperty
	a_turn_up: assert property (p_turn_up)
		else $error("turn counter missed forward wrap");

	property p_turn_dn;
		@(posedge clock) disable iff (!resetn)
		take && angle_code[7:6] == 2'h0 && next_code[7:6] == 2'h3
			|=> turns == 8'($past(turns) - 8'h01);
	endproperty
	a_turn_dn: assert property (p_turn_dn)
		else $error("turn counter missed reverse wrap");

	property p_wake_clear;
		@(posedge clock) disable iff (!resetn)
		readout_done && !motion |=> !wake_oe;
	endproperty
	a_wake_clear: assert property (p_wake_clear)
		else $error("wake not released after readout");

	property p_zero_cap;
		@(posedge clock) disable iff (!resetn)
		zero_set |=> zero_pos == $past(quant);
	endproperty
	a_zero_cap: assert property (p_zero_cap)
		else $error("zero position not captured");

	property p_stall;
		@(posedge clock) disable iff (!resetn)
		angle_valid && !angle_ready |=> $stable(angle_code);
	endproperty
	a_stall: assert property (p_stall)
		else $error("refused sample changed the angle code");

	property p_code_hold;
		@(posedge clock) disable iff (!resetn)
		!take |=> $stable(stored_angle);
	endproperty
	a_code_hold: assert property (p_code_hold)
		else $error("stored angle moved without a sample");

	property p_turn_hold;
		@(posedge clock) disable iff (!resetn)
		!take |=> $stable(turns);
	endproperty
	a_turn_hold: assert property (p_turn_hold)
		else $error("turn counter moved without a sample");

	property p_wake_idle;
		@(posedge clock) disable iff (!resetn)
		!motion && !wake_oe |=> !wake_oe;
	endproperty
	a_wake_idle: assert property (p_wake_idle)
		else $error("wake asserted without motion");

	property p_pwm_latch;
		@(posedge clock) disable iff (!resetn)
		period_end |=> pwm_code == $past(angle_code);
	endproperty
	a_pwm_latch: assert property (p_pwm_latch)
		else $error("pulse code not latched at period end");

	property p_frozen;
		@(posedge clock) disable iff (!resetn)
		cs_sync |=> $stable(shadow);
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("readout word moved during a frame");
endmodule : rao_top
`default_nettype wire

// ==== tb_rotary_angle_output_logic.sv ====
// Self-checking bench of the rotary angle output logic
`timescale 1ns/10ps
`default_nettype none
module tb_rotary_angle_output_logic;
	logic        clock, resetn, angle_valid, field_weak, zero_set;
	logic        polling_mode, angle_ready, pwm_out, field_low_flag;
	logic        wake_out, wake_oe, sclk, cs, sdi, sdo, sdoe, ok;
	logic [11:0] raw_angle;
	logic [7:0]  zero, code, turns;
	logic [15:0] w, old;
	logic [11:0] seq [6] = '{12'hD20, 12'h0A0, 12'h160, 12'h0F0,
		12'h120, 12'h7E0};
	int          fail_count = 0;
	int          n_checks = 0;
	int          cycles = 0;
	int          k, n;

	rao_top dut (.clock(clock), .resetn(resetn), .raw_angle(raw_angle),
		.angle_valid(angle_valid), .angle_ready(angle_ready),
		.field_weak(field_weak), .zero_set(zero_set),
		.polling_mode(polling_mode), .serial_shift_clock(sclk),
		.chip_select(cs), .serial_data_in(sdi), .serial_data_out(sdo),
		.serial_data_oe(sdoe), .pwm_out(pwm_out),
		.field_low_flag(field_low_flag), .wake_out(wake_out),
		.wake_oe(wake_oe));
	rao_host_model host (.serial_shift_clock(sclk), .chip_select(cs),
		.serial_data_in(sdi), .serial_data_out(sdo),
		.serial_data_oe(sdoe));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Ceiling covers three PWM periods plus the other scenarios
	always @(posedge clock) begin
		cycles++;
		if (cycles == 80000) begin
			fail_count++;
			$display("[FAIL] timeout expected 0 seen 1");
			tally_and_finish;
		end
	end

	// ==========================================
	// Tasks
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	task cyc(input int c);
		repeat (c) @(negedge clock);
	endtask : cyc
	// Offer one sample, hold until taken, update the expected word
	task send(input logic [11:0] r);
		logic [7:0] nc;
		@(posedge clock);
		raw_angle <= r;
		angle_valid <= 1'b1;
		k = 0;
		@(negedge clock);
		while (angle_ready !== 1'b1 && k < 50) begin
			@(negedge clock);
			k++;
		end
		chk("ready_wait", 1'b1, angle_ready);
		@(posedge clock);
		angle_valid <= 1'b0;
		nc = r[11:4] - zero;
		if (code[7:6] == 2'h3 && nc[7:6] == 2'h0)
			turns++;
		else if (code[7:6] == 2'h0 && nc[7:6] == 2'h3)
			turns--;
		code = nc;
	endtask : send
	task frame_chk;
		cyc(10);
		host.read_frame(w, ok);
		chk("word", {turns, code}, w);
		chk("oe_frame", 1'b1, ok);
		chk("oe_idle", 1'b0, sdoe);
	endtask : frame_chk

	// ==========================================
	// Main sequence
	initial begin
		resetn = 1'b0;
		angle_valid = 1'b0;
		raw_angle = 12'h000;
		field_weak = 1'b0;
		zero_set = 1'b0;
		polling_mode = 1'b0;
		zero = 8'h00;
		code = 8'h00;
		turns = 8'h00;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		@(negedge clock);
		chk("ready", 1'b1, angle_ready);
		chk("wake_oe", 1'b0, wake_oe);
		chk("pwm", 1'b0, pwm_out);
		chk("flag", 1'b0, field_low_flag);
		@(posedge clock);
		field_weak <= 1'b1;
		cyc(2);
		chk("flag", 1'b0, field_low_flag);
		cyc(3);
		chk("flag", 1'b1, field_low_flag);
		@(posedge clock);
		field_weak <= 1'b0;
		cyc(5);
		chk("flag", 1'b0, field_low_flag);
		@(posedge clock);
		raw_angle <= 12'h123;
		zero_set <= 1'b1;
		@(posedge clock);
		zero_set <= 1'b0;
		zero = 8'h12;
		// Wraps both ways, starting with a wrap down from reset
		foreach (seq[i]) begin
			send(seq[i]);
			frame_chk;
		end
		@(posedge clock);
		polling_mode <= 1'b1;
		send(12'h7E5);
		cyc(2);
		chk("wake_oe", 1'b0, wake_oe);
		send(12'h800);
		cyc(1);
		chk("wake_oe", 1'b1, wake_oe);
		chk("wake_out", 1'b0, wake_out);
		cyc(20);
		chk("wake_oe", 1'b1, wake_oe);
		frame_chk;
		chk("wake_oe", 1'b0, wake_oe);
		// Select high freezes the link, so the buffer fills
		old = {turns, code};
		host.open_frame;
		send(12'h100);
		send(12'h200);
		send(12'h300);
		send(12'h400);
		cyc(1);
		chk("ready_full", 1'b0, angle_ready);
		@(posedge clock);
		raw_angle <= 12'hF00;
		angle_valid <= 1'b1;
		cyc(3);
		chk("ready_full", 1'b0, angle_ready);
		@(posedge clock);
		angle_valid <= 1'b0;
		host.shift_word(w, ok);
		chk("frozen", old, w);
		host.close_frame;
		frame_chk;
		chk("ready", 1'b1, angle_ready);
		send(12'h150);
		// skip a possibly stale pulse, then time a fresh one
		while (pwm_out !== 1'b1) @(negedge clock);
		while (pwm_out === 1'b1) @(negedge clock);
		while (pwm_out !== 1'b1) @(negedge clock);
		n = 0;
		while (pwm_out === 1'b1) begin
			n++;
			@(negedge clock);
		end
		chk("pwm_high", 16'h00C8, 16'(n));
		tally_and_finish;
	end
endmodule : tb_rotary_angle_output_logic
`default_nettype wire
